// ### dat_config.sv
// address and timing configuration interpreter for the diagnostic tool
// takes one parsed command at a time on the same clock, checks it,
// updates settings and answers OK or ? then a prompt
//
// Contract
// - address command: header, then optional receiver, then optional timeout.
// - 11-bit or 29-bit ids, optional extension byte, or a 24-bit header.
// - six-digit header is the non-CAN header, even under CAN.
// - keep-current token leaves that setting unchanged, others still applied.
// - reply timeout is one byte, each unit 4.096 ms.
// - double-star receiver drops its upper 8 bits from the mask.
// - each single star drops its nibble from the mask.
// - extension byte on header enters extended mode; receiver extension only then.
// - mismatched header and receiver forms reject with '?', nothing changes.
// - extended mode, no receiver: use stored receive extension setting.
// - flow wait command sets FC wait, parameter times 4.096 ms.
// - flow wait below 0x14 is rejected.
// - flow wait resets to 0x7A.
// - gap command sets raw multi-frame spacing in milliseconds.
// - gap resets to zero.
`timescale 1ns/1ps
`default_nettype none

module dat_config #(
  parameter int WAIT_UNIT_CYC = dat_pkg::DAT_WAIT_UNIT_CYC,  // cycles per 4.096 ms
  parameter int GAP_UNIT_CYC  = dat_pkg::DAT_GAP_UNIT_CYC    // cycles per 1 ms
) (
  input  wire logic        i_clk_sys,            // 25 MHz system clock
  input  wire logic        i_rst_n,              // synchronous reset, low active
  input  wire logic        i_cmd_valid,          // command strobe, one cycle
  input  wire logic [1:0]  i_cmd_op,             // dat_op_t
  input  wire logic [1:0]  i_hdr_kind,           // first position kind
  input  wire logic [3:0]  i_hdr_digits,         // hex digits before the dash
  input  wire logic [28:0] i_hdr_value,          // header value, right aligned
  input  wire logic        i_hdr_ext_present,    // header had -hh
  input  wire logic [7:0]  i_hdr_ext,            // header extension byte
  input  wire logic [1:0]  i_rcv_kind,           // second position kind
  input  wire logic [3:0]  i_rcv_digits,         // hex digits before the dash
  input  wire logic [28:0] i_rcv_value,          // receiver value, stars as 0
  input  wire logic [7:0]  i_rcv_nib_wild,       // bit n: nibble n was a star
  input  wire logic        i_rcv_dstar,          // receiver led by double star
  input  wire logic        i_rcv_ext_present,    // receiver had -hh
  input  wire logic [7:0]  i_rcv_ext,            // receiver extension byte
  input  wire logic        i_rcv_ext_wild,       // receiver extension was **
  input  wire logic [1:0]  i_tmo_kind,           // third position kind
  input  wire logic [7:0]  i_arg,                // timeout, wait or gap byte
  input  wire logic [7:0]  i_rx_ext_addr_setting, // rx_ext_addr_setting value
  output logic             o_cmd_ready,          // idle, next command taken
  output logic [1:0]       o_rsp_code,           // dat_rsp_t, valid with strobe
  output logic             o_rsp_valid,          // answer strobe, one cycle
  output logic [28:0]      o_tx_header_param,    // CAN transmit id
  output logic             o_tx_is_29bit,        // transmit id is 29-bit
  output logic [7:0]       o_tx_ext_addr,        // transmit extension byte
  output logic             o_ext_mode,           // CAN extended address mode
  output logic [23:0]      o_nc_header,          // non-CAN transmit header
  output logic [28:0]      o_rx_filter,          // CAN receive filter
  output logic [28:0]      o_rx_mask,            // CAN receive mask
  output logic             o_rx_is_29bit,        // receive filter is 29-bit
  output logic [7:0]       o_rx_ext_addr,        // receive extension filter
  output logic [7:0]       o_rx_ext_mask,        // receive extension mask
  output logic [23:0]      o_nc_pass_filter,     // non-CAN pass filter
  output logic [23:0]      o_nc_pass_mask,       // non-CAN pass mask
  output logic [7:0]       o_reply_timeout,      // reply timeout units
  output logic [7:0]       o_flow_wait,          // FC wait units
  output logic [7:0]       o_gap_ms,             // multi-frame gap in ms
  output logic [31:0]      o_reply_cycles,       // reply timeout in clocks
  output logic [31:0]      o_flow_cycles,        // FC wait in clocks
  output logic [31:0]      o_gap_cycles          // gap in clocks
);

  // ---------------------------------------------------------------
  // answer sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DAT_ST_IDLE   = 2'b01,
    DAT_ST_ANSWER = 2'b10,
    DAT_ST_PROMPT = 2'b00
  } dat_state_t;

  localparam logic [31:0] WAIT_UNIT = 32'(WAIT_UNIT_CYC);
  localparam logic [31:0] GAP_UNIT  = 32'(GAP_UNIT_CYC);

  dat_state_t  state_reg, state_next;
  logic [1:0]  rsp_code_reg, rsp_code_next;
  logic        rsp_valid_reg, rsp_valid_next;
  logic        pend_ok_reg, pend_ok_next;
  logic [28:0] tx_hdr_reg, tx_hdr_next;
  logic        tx29_reg, tx29_next;
  logic [7:0]  tx_ext_reg, tx_ext_next;
  logic        ext_mode_reg, ext_mode_next;
  logic [23:0] nc_hdr_reg, nc_hdr_next;
  logic [28:0] rx_flt_reg, rx_flt_next;
  logic [28:0] rx_msk_reg, rx_msk_next;
  logic        rx29_reg, rx29_next;
  logic [7:0]  rx_ext_reg, rx_ext_next;
  logic [7:0]  rx_emsk_reg, rx_emsk_next;
  logic [23:0] nc_flt_reg, nc_flt_next;
  logic [23:0] nc_msk_reg, nc_msk_next;
  logic [7:0]  reply_reg, reply_next;
  logic [7:0]  flow_reg, flow_next;
  logic [7:0]  gap_reg, gap_next;
  logic [31:0] reply_cyc_reg, reply_cyc_next;
  logic [31:0] flow_cyc_reg, flow_cyc_next;
  logic [31:0] gap_cyc_reg, gap_cyc_next;

  // ---------------------------------------------------------------
  // parameter classification
  // ---------------------------------------------------------------
  logic        hdr_val, hdr_can, hdr_nc, hdr_bad;
  logic        rcv_val, rcv_can, rcv_nc, rcv_bad, rcv_given;
  logic        new_ext_mode, addr_reject, tmo_apply, take;
  logic [28:0] nib_keep, rcv_mask;

  // a star nibble is cleared from the mask, one term per nibble
  for (genvar n = 0; n < 8; n++) begin : g_nib
    if (n < 7) begin : g_full
      assign nib_keep[4*n+3:4*n] = i_rcv_nib_wild[n] ? 4'h0 : 4'hF;
    end else begin : g_top
      assign nib_keep[28] = ~i_rcv_nib_wild[n];
    end
  end

  // form checks on the two address positions
  always_comb begin
    hdr_val   = (i_hdr_kind == dat_pkg::DAT_PK_VALUE);
    hdr_can   = hdr_val && ((i_hdr_digits == dat_pkg::DAT_DIG_CAN11) ||
                            (i_hdr_digits == dat_pkg::DAT_DIG_CAN29));
    hdr_nc    = hdr_val && (i_hdr_digits == dat_pkg::DAT_DIG_NONCAN);
    hdr_bad   = (i_hdr_kind == dat_pkg::DAT_PK_BAD) ||
                (i_hdr_kind == dat_pkg::DAT_PK_ABSENT) ||
                (hdr_val && !hdr_can && !hdr_nc) ||
                (hdr_nc && i_hdr_ext_present);
    rcv_val   = (i_rcv_kind == dat_pkg::DAT_PK_VALUE);
    rcv_given = (i_rcv_kind != dat_pkg::DAT_PK_ABSENT);
    rcv_can   = rcv_val && ((i_rcv_digits == dat_pkg::DAT_DIG_CAN11) ||
                            (i_rcv_digits == dat_pkg::DAT_DIG_CAN29));
    rcv_nc    = rcv_val && (i_rcv_digits == dat_pkg::DAT_DIG_NONCAN);
    rcv_bad   = (i_rcv_kind == dat_pkg::DAT_PK_BAD) ||
                (rcv_val && !rcv_can && !rcv_nc) ||
                (rcv_nc && i_rcv_ext_present);
    // only a CAN header decides the mode; keep token or 24-bit leave it
    new_ext_mode = hdr_can ? i_hdr_ext_present : ext_mode_reg;
    addr_reject  = hdr_bad || rcv_bad ||
                   (rcv_can && i_rcv_ext_present && !new_ext_mode) ||
                   (rcv_can && !i_rcv_ext_present && new_ext_mode) ||
                   (i_tmo_kind == dat_pkg::DAT_PK_BAD);
    tmo_apply    = (i_tmo_kind == dat_pkg::DAT_PK_VALUE) && rcv_given;
  end

  // receive mask from form width, stars and a double star
  always_comb begin
    if (i_rcv_digits == dat_pkg::DAT_DIG_CAN29) begin
      rcv_mask = dat_pkg::DAT_MASK_CAN29 & nib_keep;
      if (i_rcv_dstar) begin
        rcv_mask[dat_pkg::DAT_TOP_CAN29 -: dat_pkg::DAT_DSTAR_BITS] = 8'h00;
      end
    end else if (i_rcv_digits == dat_pkg::DAT_DIG_NONCAN) begin
      rcv_mask = dat_pkg::DAT_MASK_NC24 & nib_keep;
      if (i_rcv_dstar) begin
        rcv_mask[dat_pkg::DAT_TOP_NC24 -: dat_pkg::DAT_DSTAR_BITS] = 8'h00;
      end
    end else begin
      rcv_mask = dat_pkg::DAT_MASK_CAN11 & nib_keep;
      if (i_rcv_dstar) begin
        rcv_mask[dat_pkg::DAT_TOP_CAN11 -: dat_pkg::DAT_DSTAR_BITS] = 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // command execution and answer sequencing
  // ---------------------------------------------------------------
  // a command is only taken while idle, so settings never change mid-answer
  always_comb begin
    take           = i_cmd_valid && (state_reg == DAT_ST_IDLE);
    state_next     = state_reg;
    rsp_code_next  = dat_pkg::DAT_RSP_NONE;
    rsp_valid_next = 1'b0;
    pend_ok_next   = pend_ok_reg;
    tx_hdr_next    = tx_hdr_reg;
    tx29_next      = tx29_reg;
    tx_ext_next    = tx_ext_reg;
    ext_mode_next  = ext_mode_reg;
    nc_hdr_next    = nc_hdr_reg;
    rx_flt_next    = rx_flt_reg;
    rx_msk_next    = rx_msk_reg;
    rx29_next      = rx29_reg;
    rx_ext_next    = rx_ext_reg;
    rx_emsk_next   = rx_emsk_reg;
    nc_flt_next    = nc_flt_reg;
    nc_msk_next    = nc_msk_reg;
    reply_next     = reply_reg;
    flow_next      = flow_reg;
    gap_next       = gap_reg;
    case (state_reg)
      DAT_ST_IDLE: begin
        if (take) begin
          state_next   = DAT_ST_ANSWER;
          pend_ok_next = 1'b0;
          case (dat_pkg::dat_op_t'(i_cmd_op))
            dat_pkg::DAT_OP_SET_ADDRESS: begin
              // a rejected command changes nothing
              if (!addr_reject) begin
                pend_ok_next = 1'b1;
                if (hdr_can) begin
                  tx_hdr_next   = i_hdr_value;
                  tx29_next     = (i_hdr_digits == dat_pkg::DAT_DIG_CAN29);
                  ext_mode_next = i_hdr_ext_present;
                  if (i_hdr_ext_present) begin
                    tx_ext_next = i_hdr_ext;
                  end
                end else if (hdr_nc) begin
                  nc_hdr_next = i_hdr_value[23:0];
                end
                if (rcv_can) begin
                  rx_flt_next = i_rcv_value & rcv_mask;
                  rx_msk_next = rcv_mask;
                  rx29_next   = (i_rcv_digits == dat_pkg::DAT_DIG_CAN29);
                  if (i_rcv_ext_present) begin
                    rx_ext_next  = i_rcv_ext;
                    rx_emsk_next = i_rcv_ext_wild ? 8'h00 : dat_pkg::DAT_EXT_FULL;
                  end
                end else if (rcv_nc) begin
                  nc_flt_next = i_rcv_value[23:0] & rcv_mask[23:0];
                  nc_msk_next = rcv_mask[23:0];
                end
                if (!rcv_given && new_ext_mode) begin
                  rx_ext_next  = i_rx_ext_addr_setting;
                  rx_emsk_next = dat_pkg::DAT_EXT_FULL;
                end
                if (tmo_apply) begin
                  reply_next = i_arg;
                end
              end
            end
            dat_pkg::DAT_OP_FLOW_WAIT: begin
              if (i_arg >= dat_pkg::DAT_MIN_FLOW_WAIT) begin
                pend_ok_next = 1'b1;
                flow_next    = i_arg;
              end
            end
            dat_pkg::DAT_OP_GAP: begin
              pend_ok_next = 1'b1;
              gap_next     = i_arg;
            end
            default: begin
              pend_ok_next = 1'b0;
            end
          endcase
        end
      end
      DAT_ST_ANSWER: begin
        rsp_valid_next = 1'b1;
        rsp_code_next  = pend_ok_reg ? dat_pkg::DAT_RSP_OK : dat_pkg::DAT_RSP_REJECT;
        state_next     = DAT_ST_PROMPT;
      end
      DAT_ST_PROMPT: begin
        rsp_valid_next = 1'b1;
        rsp_code_next  = dat_pkg::DAT_RSP_PROMPT;
        state_next     = DAT_ST_IDLE;
      end
      default: begin
        state_next = DAT_ST_IDLE;
      end
    endcase
  end

  // timing counts follow the stored units, one cycle behind them
  always_comb begin
    reply_cyc_next = 32'(reply_reg) * WAIT_UNIT;
    flow_cyc_next  = 32'(flow_reg) * WAIT_UNIT;
    gap_cyc_next   = 32'(gap_reg) * GAP_UNIT;
  end

  // registers only; reset loads the defaults
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_reg     <= DAT_ST_IDLE;
      rsp_code_reg  <= dat_pkg::DAT_RSP_NONE;
      rsp_valid_reg <= 1'b0;
      pend_ok_reg   <= 1'b0;
      tx_hdr_reg    <= 29'h0000_0000;
      tx29_reg      <= 1'b0;
      tx_ext_reg    <= 8'h00;
      ext_mode_reg  <= 1'b0;
      nc_hdr_reg    <= 24'h00_0000;
      rx_flt_reg    <= 29'h0000_0000;
      rx_msk_reg    <= 29'h0000_0000;
      rx29_reg      <= 1'b0;
      rx_ext_reg    <= 8'h00;
      rx_emsk_reg   <= 8'h00;
      nc_flt_reg    <= 24'h00_0000;
      nc_msk_reg    <= 24'h00_0000;
      reply_reg     <= dat_pkg::DAT_RST_REPLY;
      flow_reg      <= dat_pkg::DAT_RST_FLOW_WAIT;
      gap_reg       <= dat_pkg::DAT_RST_GAP;
      reply_cyc_reg <= 32'h0000_0000;
      flow_cyc_reg  <= 32'h0000_0000;
      gap_cyc_reg   <= 32'h0000_0000;
    end else begin
      state_reg     <= state_next;
      rsp_code_reg  <= rsp_code_next;
      rsp_valid_reg <= rsp_valid_next;
      pend_ok_reg   <= pend_ok_next;
      tx_hdr_reg    <= tx_hdr_next;
      tx29_reg      <= tx29_next;
      tx_ext_reg    <= tx_ext_next;
      ext_mode_reg  <= ext_mode_next;
      nc_hdr_reg    <= nc_hdr_next;
      rx_flt_reg    <= rx_flt_next;
      rx_msk_reg    <= rx_msk_next;
      rx29_reg      <= rx29_next;
      rx_ext_reg    <= rx_ext_next;
      rx_emsk_reg   <= rx_emsk_next;
      nc_flt_reg    <= nc_flt_next;
      nc_msk_reg    <= nc_msk_next;
      reply_reg     <= reply_next;
      flow_reg      <= flow_next;
      gap_reg       <= gap_next;
      reply_cyc_reg <= reply_cyc_next;
      flow_cyc_reg  <= flow_cyc_next;
      gap_cyc_reg   <= gap_cyc_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flip-flops
  // ---------------------------------------------------------------
  // ready is bit 0 of the state flop, set only in idle
  always_comb begin
    o_cmd_ready       = state_reg[0];
    o_rsp_code        = rsp_code_reg;
    o_rsp_valid       = rsp_valid_reg;
    o_tx_header_param = tx_hdr_reg;
    o_tx_is_29bit     = tx29_reg;
    o_tx_ext_addr     = tx_ext_reg;
    o_ext_mode        = ext_mode_reg;
    o_nc_header       = nc_hdr_reg;
    o_rx_filter       = rx_flt_reg;
    o_rx_mask         = rx_msk_reg;
    o_rx_is_29bit     = rx29_reg;
    o_rx_ext_addr     = rx_ext_reg;
    o_rx_ext_mask     = rx_emsk_reg;
    o_nc_pass_filter  = nc_flt_reg;
    o_nc_pass_mask    = nc_msk_reg;
    o_reply_timeout   = reply_reg;
    o_flow_wait       = flow_reg;
    o_gap_ms          = gap_reg;
    o_reply_cycles    = reply_cyc_reg;
    o_flow_cycles     = flow_cyc_reg;
    o_gap_cycles      = gap_cyc_reg;
  end

endmodule

`default_nettype wire

// ### dat_config_monitor.sv
// checker for dat_config: handshake, answer order and timing settings
// bound onto dat_config, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module dat_config_monitor #(
  parameter int WAIT_UNIT_CYC = dat_pkg::DAT_WAIT_UNIT_CYC  // cycles per wait unit
) (
  input wire logic        i_clk_sys,          // clock
  input wire logic        i_rst_n,            // sync reset
  input wire logic        i_cmd_valid,        // strobe
  input wire logic [1:0]  i_cmd_op,           // command
  input wire logic [1:0]  i_hdr_kind,         // header kind
  input wire logic [7:0]  i_arg,              // byte argument
  input wire logic        o_cmd_ready,        // idle
  input wire logic        o_rsp_valid,        // answer strobe
  input wire logic [1:0]  o_rsp_code,         // answer code
  input wire logic [28:0] o_tx_header_param,  // tx id
  input wire logic [7:0]  o_flow_wait,        // fc wait
  input wire logic [7:0]  o_gap_ms,           // gap
  input wire logic [31:0] o_flow_cycles       // fc wait clocks
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  localparam logic [1:0] REJ = dat_pkg::DAT_RSP_REJECT;
  logic take;
  assign take = i_cmd_valid && o_cmd_ready;  // a request is only taken while idle
  sequence s_verdict;
    o_rsp_valid && (o_rsp_code == dat_pkg::DAT_RSP_OK || o_rsp_code == REJ);
  endsequence
  sequence s_prompt;
    o_rsp_valid && o_rsp_code == dat_pkg::DAT_RSP_PROMPT;
  endsequence
  a_busy_window: assert property (take |=> !o_cmd_ready [*2] ##1 o_cmd_ready)
    else $error("ready not low for two cycles");
  a_answer_order: assert property (take |=> !o_rsp_valid ##1 s_verdict ##1 s_prompt)
    else $error("answer then prompt missing");
  a_bad_op: assert property (take && i_cmd_op == dat_pkg::DAT_OP_NONE |=> ##1 o_rsp_code == REJ)
    else $error("unknown command accepted");
  a_flow_floor: assert property (o_flow_wait >= dat_pkg::DAT_MIN_FLOW_WAIT)
    else $error("flow wait below floor");
  a_flow_set: assert property (take && i_cmd_op == dat_pkg::DAT_OP_FLOW_WAIT && i_arg >= 8'h14
    |=> o_flow_wait == $past(i_arg)) else $error("flow wait not stored");
  a_flow_refuse: assert property (take && i_cmd_op == dat_pkg::DAT_OP_FLOW_WAIT && i_arg < 8'h14
    |=> $stable(o_flow_wait) ##1 o_rsp_code == REJ) else $error("small flow wait taken");
  a_gap_set: assert property (take && i_cmd_op == dat_pkg::DAT_OP_GAP
    |=> o_gap_ms == $past(i_arg) ##1 o_rsp_code == dat_pkg::DAT_RSP_OK) else $error("gap not stored");
  a_flow_cycles: assert property (!$rose(i_rst_n)
    |-> o_flow_cycles == 32'($past(o_flow_wait)) * WAIT_UNIT_CYC) else $error("flow clocks wrong");
  a_keep_header: assert property (take && i_cmd_op == dat_pkg::DAT_OP_SET_ADDRESS
    && i_hdr_kind == dat_pkg::DAT_PK_KEEP |=> $stable(o_tx_header_param)) else $error("header moved");
endmodule
bind dat_config dat_config_monitor #(.WAIT_UNIT_CYC(WAIT_UNIT_CYC)) dat_config_monitor_i (.*);
`default_nettype wire

// ### dat_config_tb.sv
// bench for dat_config, short wait and gap units
// assumes package, checker and host model compiled first
`timescale 1ns/1ps
`default_nettype none
module dat_config_tb;
  localparam logic [1:0] A = 2'b00, K = 2'b01, V = 2'b10, OK = 2'b01, RJ = 2'b10;
  localparam logic [1:0] SA = 2'b00, FW = 2'b01, GP = 2'b10, NO = 2'b11;
  logic        i_clk_sys = 1'b0, i_rst_n = 1'b0, i_cmd_valid = 1'b0;
  logic [1:0]  i_cmd_op, i_hdr_kind, i_rcv_kind, i_tmo_kind;
  logic [3:0]  i_hdr_digits, i_rcv_digits;
  logic [28:0] i_hdr_value, i_rcv_value;
  logic        i_hdr_ext_present, i_rcv_dstar, i_rcv_ext_present, i_rcv_ext_wild;
  logic [7:0]  i_hdr_ext, i_rcv_nib_wild, i_rcv_ext, i_arg, i_rx_ext_addr_setting, a, b, p;
  wire  logic  o_cmd_ready, o_rsp_valid, o_tx_is_29bit, o_ext_mode, o_rx_is_29bit;
  wire  logic [1:0]  o_rsp_code;
  wire  logic [7:0]  o_tx_ext_addr, o_rx_ext_addr, o_rx_ext_mask, o_reply_timeout, o_flow_wait, o_gap_ms;
  wire  logic [23:0] o_nc_header, o_nc_pass_filter, o_nc_pass_mask;
  wire  logic [28:0] o_tx_header_param, o_rx_filter, o_rx_mask;
  wire  logic [31:0] o_reply_cycles, o_flow_cycles, o_gap_cycles;
  wire  logic [15:0] prompts;
  logic [1:0]  exp_q[$];
  int          miscompares = 0, compares = 0, ncmd = 0, cyc = 0;
  dat_config #(.WAIT_UNIT_CYC(4), .GAP_UNIT_CYC(2)) dat_config_i (.*);
  dat_host_model dat_host_model_i (.i_clk_sys, .i_rst_n, .i_rsp_valid(o_rsp_valid),
    .i_rsp_code(o_rsp_code), .o_prompts(prompts));
  // ---------------------------------------------------------------
  // clock, timeout, answer watcher
  // ---------------------------------------------------------------
  initial begin
    forever #20 i_clk_sys = ~i_clk_sys;
  end
  // ceiling far above the test length
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      miscompares++;
      report_and_stop();
    end
  end
  // verdicts read at negedge, where settled
  always @(negedge i_clk_sys) begin
    if (o_rsp_valid === 1'b1 && o_rsp_code !== dat_pkg::DAT_RSP_PROMPT) begin
      chk("rsp_code", exp_q.pop_front(), o_rsp_code);
    end
  end
  task automatic chk(input string n, logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // drivers: strobe for one edge, then four idle edges
  // ---------------------------------------------------------------
  task automatic clr(input logic [1:0] op);
    i_cmd_op = op;
    {i_hdr_kind, i_rcv_kind, i_tmo_kind, i_hdr_digits, i_rcv_digits, i_hdr_value,
     i_rcv_value, i_hdr_ext_present, i_rcv_dstar, i_rcv_ext_present, i_rcv_ext_wild,
     i_hdr_ext, i_rcv_nib_wild, i_rcv_ext, i_arg} = '0;
  endtask
  task automatic go(input logic [1:0] code);
    exp_q.push_back(code);
    ncmd++;
    i_cmd_valid = 1'b1;
    @(negedge i_clk_sys);
    i_cmd_valid = 1'b0;
    repeat (4) @(negedge i_clk_sys);
  endtask
  task automatic sa(input logic [1:0] hk, logic [3:0] hd, logic [28:0] hv, logic [8:0] hx,
    logic [1:0] rk, logic [3:0] rd, logic [28:0] rv, logic [8:0] rx, logic [8:0] w,
    logic [1:0] tk, logic [7:0] t, logic [1:0] code);
    clr(SA);
    {i_hdr_kind, i_hdr_digits, i_hdr_value, i_hdr_ext_present, i_hdr_ext} = {hk, hd, hv, hx};
    {i_rcv_kind, i_rcv_digits, i_rcv_value, i_rcv_ext_present, i_rcv_ext} = {rk, rd, rv, rx};
    {i_rcv_dstar, i_rcv_nib_wild, i_tmo_kind, i_arg} = {w, tk, t};
    go(code);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h9032));
    clr(NO);
    i_rx_ext_addr_setting = 8'($urandom());
    repeat (10) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    chk("flow_wait", 32'h0000_007A, o_flow_wait);
    chk("gap_ms", 32'h0000_0000, o_gap_ms);
    for (int n = 0; n < 8; n++) begin
      a = (n == 0) ? 8'h13 : (n == 1) ? 8'h14 : 8'($urandom());
      p = (a >= 8'h14) ? a : o_flow_wait;
      b = ~a;
      clr(FW);
      i_arg = a;
      go((a >= 8'h14) ? OK : RJ);
      chk("flow_wait", p, o_flow_wait);
      chk("flow_cycles", 32'(p) * 4, o_flow_cycles);
      clr(GP);
      i_arg = b;
      go(OK);
      chk("gap_ms", b, o_gap_ms);
      chk("gap_cycles", 32'(b) * 2, o_gap_cycles);
    end
    sa(V, 3, 29'h7DF, 0, V, 3, 29'h7E8, 0, 0, V, 8'h50, OK);
    chk("tx_header", 29'h7DF, o_tx_header_param);
    chk("rx_mask", 29'h7FF, o_rx_mask);
    chk("reply_cycles", 32'h0000_0140, o_reply_cycles);
    sa(K, 0, 0, 0, V, 3, 29'h7E8, 9'h120, 0, A, 0, RJ);
    sa(V, 3, 29'h7E0, 9'h140, V, 3, 29'h7E1, 0, 0, A, 0, RJ);
    chk("tx_header", 29'h7DF, o_tx_header_param);
    chk("rx_filter", 29'h7E8, o_rx_filter);
    sa(V, 3, 29'h7DF, 9'h140, V, 3, 29'h7E8, 9'h1F1, 0, A, 0, OK);
    chk("ext_mode", 1, o_ext_mode);
    chk("ext_set", 24'h40_F1FF, {o_tx_ext_addr, o_rx_ext_addr, o_rx_ext_mask});
    sa(V, 3, 29'h7E0, 9'h110, A, 0, 0, 0, 0, A, 0, OK);
    chk("rx_ext", i_rx_ext_addr_setting, o_rx_ext_addr);
    sa(K, 0, 0, 0, K, 0, 0, 0, 0, V, 8'hC3, OK);
    chk("reply", 8'hC3, o_reply_timeout);
    chk("tx_header", 29'h7E0, o_tx_header_param);
    sa(V, 3, 29'h7DF, 0, V, 3, 29'h7E0, 0, 9'h001, A, 0, OK);
    chk("rx_mask", 29'h7F0, o_rx_mask);
    sa(V, 6, 29'hCF_33F1, 0, V, 6, 29'h00_F110, 0, 9'h100, A, 0, OK);
    chk("nc_header", 24'hCF_33F1, o_nc_header);
    chk("tx_header", 29'h7DF, o_tx_header_param);
    chk("nc_pass", 48'h00F1_1000_FFFF, {o_nc_pass_filter, o_nc_pass_mask});
    sa(V, 8, 29'h18DA_10F1, 0, V, 8, 29'h18DA_F110, 0, 0, A, 0, OK);
    chk("widths", 3'b101, {o_tx_is_29bit, o_ext_mode, o_rx_is_29bit});
    chk("rx_mask", 29'h1FFF_FFFF, o_rx_mask);
    clr(NO);
    go(RJ);
    chk("prompts", ncmd, prompts);
    report_and_stop();
  end
endmodule
`default_nettype wire

// ### dat_host_model.sv
// host side of the command link: collects answers and prompts
// assumes one-cycle answer strobes on the shared clock
`timescale 1ns/1ps
`default_nettype none
module dat_host_model (
  input  wire logic       i_clk_sys,    // clock
  input  wire logic       i_rst_n,      // sync reset
  input  wire logic       i_rsp_valid,  // answer strobe
  input  wire logic [1:0] i_rsp_code,   // answer code
  output var  logic [15:0] o_prompts    // prompts seen after a verdict
);
  logic pend;
  // a prompt counts only after a verdict, so strays show
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pend <= 1'b0;
      o_prompts <= 16'h0000;
    end else if (i_rsp_valid && i_rsp_code == dat_pkg::DAT_RSP_PROMPT) begin
      pend <= 1'b0;
      o_prompts <= o_prompts + 16'(pend);
    end else if (i_rsp_valid) begin
      pend <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ### dat_pkg.sv
// package for the diagnostic address and timing configuration block
// holds command codes, parameter kinds, reset values and timing counts;
// assumes a 25 MHz system clock shared by every user of this package
package dat_pkg;

  // ---------------------------------------------------------------
  // command codes delivered by the upstream text parser
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DAT_OP_SET_ADDRESS = 2'b00,  // set_address_cmd
    DAT_OP_FLOW_WAIT   = 2'b01,  // flow_wait_timeout_cmd
    DAT_OP_GAP         = 2'b10,  // multi_frame_gap_cmd
    DAT_OP_NONE        = 2'b11   // anything else, always rejected
  } dat_op_t;

  // ---------------------------------------------------------------
  // kind of one parameter position
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DAT_PK_ABSENT = 2'b00,       // position not given
    DAT_PK_KEEP   = 2'b01,       // keep_current_token
    DAT_PK_VALUE  = 2'b10,       // hex value given
    DAT_PK_BAD    = 2'b11        // malformed text
  } dat_pkind_t;

  // ---------------------------------------------------------------
  // answer codes
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    DAT_RSP_NONE   = 2'b00,
    DAT_RSP_OK     = 2'b01,      // "OK"
    DAT_RSP_REJECT = 2'b10,      // "?"
    DAT_RSP_PROMPT = 2'b11       // ">" after the answer
  } dat_rsp_t;

  // ---------------------------------------------------------------
  // address forms, counted in hex digits
  // ---------------------------------------------------------------
  localparam logic [3:0]  DAT_DIG_CAN11  = 4'h3;
  localparam logic [3:0]  DAT_DIG_NONCAN = 4'h6;
  localparam logic [3:0]  DAT_DIG_CAN29  = 4'h8;
  localparam logic [28:0] DAT_MASK_CAN11 = 29'h0000_07FF;
  localparam logic [28:0] DAT_MASK_CAN29 = 29'h1FFF_FFFF;
  localparam logic [28:0] DAT_MASK_NC24  = 29'h00FF_FFFF;
  localparam int          DAT_TOP_CAN11  = 10;   // msb of an 11-bit id
  localparam int          DAT_TOP_NC24   = 23;   // msb of a 24-bit header
  localparam int          DAT_TOP_CAN29  = 28;   // msb of a 29-bit id
  localparam int          DAT_DSTAR_BITS = 8;    // bits dropped by a double star

  // ---------------------------------------------------------------
  // reset values and limits
  // ---------------------------------------------------------------
  localparam logic [7:0]  DAT_RST_FLOW_WAIT = 8'h7A;  // about 500 ms
  localparam logic [7:0]  DAT_RST_GAP       = 8'h00;
  localparam logic [7:0]  DAT_RST_REPLY     = 8'h00;
  localparam logic [7:0]  DAT_MIN_FLOW_WAIT = 8'h14;
  localparam logic [7:0]  DAT_EXT_FULL      = 8'hFF;

  // ---------------------------------------------------------------
  // timing: units as printed, cycle counts derived from the clock
  // ---------------------------------------------------------------
  // counted in ns: a 4.096 ms unit in ps would overflow an int
  localparam int DAT_CLK_PERIOD_NS = 40;        // 25 MHz
  localparam int DAT_WAIT_UNIT_NS  = 4096000;   // 4.096 ms, in ns
  localparam int DAT_GAP_UNIT_NS   = 1000000;   // 1 ms, in ns
  localparam int DAT_WAIT_UNIT_CYC = DAT_WAIT_UNIT_NS / DAT_CLK_PERIOD_NS;
  localparam int DAT_GAP_UNIT_CYC  = DAT_GAP_UNIT_NS / DAT_CLK_PERIOD_NS;

endpackage
